// ===== include/ocs_pkg.sv
// Constants, register map and types of the oscillator clock select block
package ocs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] OCS_IDX_OPTION = 16'hffcf;
    localparam logic [15:0] OCS_IDX_CONFIG = 16'h001d;
    localparam logic [15:0] OCS_IDX_STATUS = 16'h001e;
    localparam int OCS_IDX_LSB = 2;
    localparam int OCS_ADDR_W = 18;

    // Main reference source codes
    localparam logic [1:0] OCS_MAIN_UNUSED = 2'h0;
    localparam logic [1:0] OCS_MAIN_INT = 2'h1;
    localparam logic [1:0] OCS_MAIN_RC = 2'h2;
    localparam logic [1:0] OCS_MAIN_XTAL = 2'h3;

    // Timebase reference source codes
    localparam logic [1:0] OCS_TB_INT = 2'h0;
    localparam logic [1:0] OCS_TB_RC = 2'h1;
    localparam logic [1:0] OCS_TB_XTAL = 2'h2;
    localparam logic [1:0] OCS_TB_UNUSED = 2'h3;

    // Option register fields
    localparam int OCS_OPT_SEL_LO = 0;
    localparam int OCS_OPT_SEL_HI = 1;

    // Configuration register fields
    localparam int OCS_CFG_TB_LO = 0;
    localparam int OCS_CFG_TB_HI = 1;
    localparam int OCS_CFG_INTERNAL_OSC_CLOCK_OFF = 2;
    localparam int OCS_CFG_XTAL_ON = 3;
    localparam int OCS_CFG_RC_ON = 4;
    localparam logic [7:0] OCS_CFG_RESET = 8'h00;
    localparam logic [7:0] OCS_CFG_MASK = 8'h1f;

    // Status register fields
    localparam int OCS_ST_INT_EN = 0;
    localparam int OCS_ST_RC_EN = 1;
    localparam int OCS_ST_XTAL_EN = 2;
    localparam int OCS_ST_STOP = 3;
    localparam int OCS_ST_BUSY = 4;
    localparam int OCS_ST_SRC_LO = 5;
    localparam int OCS_ST_SRC_HI = 6;

    // AXI responses
    localparam logic [1:0] OCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] OCS_RESP_SLVERR = 2'h2;

    // Synchroniser input positions
    localparam int OCS_SYN_INTERNAL_OSC_CLOCK = 0;
    localparam int OCS_SYN_RC_OSC_CLOCK = 1;
    localparam int OCS_SYN_CRYSTAL_OSC_CLOCK = 2;
    localparam int OCS_SYN_BUS = 3;
    localparam int OCS_SYN_AMP = 4;
    localparam int OCS_SYN_OPT_LO = 5;
    localparam int OCS_SYN_OPT_HI = 6;
    localparam int OCS_SYN_W = 7;

    typedef enum logic [1:0] {
        OCS_SW_RUN,
        OCS_SW_PARK_OLD,
        OCS_SW_WAIT_NEW
    } ocs_switch_e;

endpackage : ocs_pkg

// ===== src/ocs_sync.sv
// Two flip-flop synchroniser for a group of level inputs
module ocs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : ocs_sync

// ===== src/ocs_top.sv
// Oscillator source selection and gating with AXI4-Lite registers
//
// The AXI4-Lite slave port was left to the implementer.
module ocs_top
    import ocs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Oscillator and pin levels
    input wire logic internal_osc_clock,
    input wire logic rc_osc_clock,
    input wire logic crystal_osc_clock,
    input wire logic crystal_amp_out,
    input wire logic bus_clock,
    input wire logic [1:0] option_strap,
    // System state from system integration
    input wire logic osc_enable_from_sysint,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic break_mode,
    // Clock outputs
    output logic main_ref_clock,
    output logic pll_ref_clock,
    output logic timebase_ref_clock,
    output logic watchdog_ref_clock,
    output logic osc_out_pin,
    // Oscillator enables
    output logic internal_osc_en,
    output logic rc_osc_en,
    output logic crystal_osc_en,
    // AXI4-Lite write address
    input wire logic [OCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [OCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic [OCS_SYN_W-1:0] syn_raw;
    logic [OCS_SYN_W-1:0] syn;
    logic [2:0] opt_loaded_q;
    logic [7:0] option_q;
    logic [7:0] config_q;
    logic stop_d1_q;
    logic [2:0] stop_keep_q;
    logic [1:0] main_req;
    logic [1:0] main_cur_q;
    ocs_switch_e sw_state_q;
    logic [1:0] tb_cur_q;
    logic tb_park_q;
    logic main_src;
    logic main_new_src;
    logic tb_src;
    logic stop_active;
    logic int_en;
    logic rc_en;
    logic xtal_en;
    logic aw_held_q;
    logic w_held_q;
    logic [15:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [15:0] ar_idx;
    logic [7:0] status_val;

    // Mode inputs kept on the port list; wait and break change nothing
    logic unused_modes;
    assign unused_modes = wait_mode | break_mode | (|s_axi_awprot) | (|s_axi_arprot);

    assign syn_raw = {option_strap[1], option_strap[0], crystal_amp_out, bus_clock,
                      crystal_osc_clock, rc_osc_clock, internal_osc_clock};

    ocs_sync #(
        .WIDTH(OCS_SYN_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(syn_raw),
        .sync_out(syn)
    );

    // Option bits caught once the synchronised strap has settled, then held
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            opt_loaded_q <= 3'h0;
            option_q <= 8'h00;
        end else if (!opt_loaded_q[2]) begin
            opt_loaded_q <= {opt_loaded_q[1:0], 1'b1};
            if (opt_loaded_q[1]) begin
                option_q <= {6'h00, syn[OCS_SYN_OPT_HI], syn[OCS_SYN_OPT_LO]};
            end
        end
    end

    assign main_req = {option_q[OCS_OPT_SEL_HI], option_q[OCS_OPT_SEL_LO]};

    // Stop-mode bits sampled on stop entry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stop_d1_q <= 1'b0;
            stop_keep_q <= 3'h0;
        end else begin
            stop_d1_q <= stop_mode;
            if (stop_mode && !stop_d1_q) begin
                stop_keep_q <= {config_q[OCS_CFG_RC_ON], config_q[OCS_CFG_XTAL_ON],
                                config_q[OCS_CFG_INTERNAL_OSC_CLOCK_OFF]};
            end
        end
    end

    assign stop_active = stop_mode && stop_d1_q;

    // Enables: one of RC/crystal at most, following the main source
    always_comb begin
        int_en = osc_enable_from_sysint && !(stop_active && stop_keep_q[0]);
        rc_en = osc_enable_from_sysint && (main_cur_q == OCS_MAIN_RC)
                && (!stop_active || stop_keep_q[2]);
        xtal_en = osc_enable_from_sysint && (main_cur_q == OCS_MAIN_XTAL)
                  && (!stop_active || stop_keep_q[1]);
    end

    function automatic logic pick_main(input logic [1:0] sel, input logic [OCS_SYN_W-1:0] s,
                                       input logic ie, input logic re, input logic xe);
        logic v;
        v = 1'b0;
        case (sel)
            OCS_MAIN_INT: v = s[OCS_SYN_INTERNAL_OSC_CLOCK] & ie;
            OCS_MAIN_RC: v = s[OCS_SYN_RC_OSC_CLOCK] & re;
            OCS_MAIN_XTAL: v = s[OCS_SYN_CRYSTAL_OSC_CLOCK] & xe;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : pick_main

    assign main_src = pick_main(main_cur_q, syn, int_en, rc_en, xtal_en);
    assign main_new_src = pick_main(main_req, syn, int_en, osc_enable_from_sysint,
                                    osc_enable_from_sysint);

    // Main source switch only while both old and new clocks are low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sw_state_q <= OCS_SW_RUN;
            main_cur_q <= OCS_MAIN_UNUSED;
        end else begin
            case (sw_state_q)
                OCS_SW_RUN: begin
                    if (main_req != main_cur_q) begin
                        sw_state_q <= OCS_SW_PARK_OLD;
                    end
                end
                OCS_SW_PARK_OLD: begin
                    if (!main_ref_clock) begin
                        sw_state_q <= OCS_SW_WAIT_NEW;
                    end
                end
                OCS_SW_WAIT_NEW: begin
                    if (!main_new_src) begin
                        main_cur_q <= main_req;
                        sw_state_q <= OCS_SW_RUN;
                    end
                end
                default: sw_state_q <= OCS_SW_RUN;
            endcase
        end
    end

    // Main, PLL and watchdog clock outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            main_ref_clock <= 1'b0;
            pll_ref_clock <= 1'b0;
        end else if (sw_state_q == OCS_SW_RUN) begin
            main_ref_clock <= main_src;
            pll_ref_clock <= main_src;
        end else if (!main_ref_clock || sw_state_q == OCS_SW_WAIT_NEW) begin
            main_ref_clock <= 1'b0;
            pll_ref_clock <= 1'b0;
        end else begin
            main_ref_clock <= main_src;
            pll_ref_clock <= main_src;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            watchdog_ref_clock <= 1'b0;
        end else begin
            watchdog_ref_clock <= syn[OCS_SYN_INTERNAL_OSC_CLOCK] & int_en;
        end
    end

    // Timebase selector; RC and crystal only when they drive the main reference
    always_comb begin
        case (tb_cur_q)
            OCS_TB_INT: tb_src = syn[OCS_SYN_INTERNAL_OSC_CLOCK] & int_en;
            OCS_TB_RC: tb_src = syn[OCS_SYN_RC_OSC_CLOCK] & rc_en;
            OCS_TB_XTAL: tb_src = syn[OCS_SYN_CRYSTAL_OSC_CLOCK] & xtal_en;
            default: tb_src = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tb_cur_q <= OCS_TB_INT;
            tb_park_q <= 1'b0;
            timebase_ref_clock <= 1'b0;
        end else if (tb_cur_q != config_q[OCS_CFG_TB_HI:OCS_CFG_TB_LO]) begin
            if (!timebase_ref_clock) begin
                tb_park_q <= 1'b1;
                tb_cur_q <= config_q[OCS_CFG_TB_HI:OCS_CFG_TB_LO];
            end else begin
                timebase_ref_clock <= tb_src;
            end
        end else if (tb_park_q) begin
            if (!tb_src) begin
                tb_park_q <= 1'b0;
            end
        end else begin
            timebase_ref_clock <= tb_src;
        end
    end

    // Second oscillator pin
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            osc_out_pin <= 1'b0;
        end else if (main_cur_q == OCS_MAIN_XTAL) begin
            osc_out_pin <= syn[OCS_SYN_AMP];
        end else if (main_cur_q == OCS_MAIN_UNUSED) begin
            osc_out_pin <= 1'b0;
        end else begin
            osc_out_pin <= syn[OCS_SYN_BUS];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            internal_osc_en <= 1'b0;
            rc_osc_en <= 1'b0;
            crystal_osc_en <= 1'b0;
        end else begin
            internal_osc_en <= int_en;
            rc_osc_en <= rc_en;
            crystal_osc_en <= xtal_en;
        end
    end

    // AXI write: address and data taken in either order
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= OCS_RESP_OKAY;
            config_q <= OCS_CFG_RESET;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[OCS_ADDR_W-1:OCS_IDX_LSB];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_idx_q == OCS_IDX_CONFIG) begin
                    if (wstrb_q[0]) begin
                        config_q <= wdata_q[7:0] & OCS_CFG_MASK;
                    end
                    s_axi_bresp <= OCS_RESP_OKAY;
                end else if (aw_idx_q == OCS_IDX_OPTION || aw_idx_q == OCS_IDX_STATUS) begin
                    s_axi_bresp <= OCS_RESP_OKAY;
                end else begin
                    s_axi_bresp <= OCS_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read
    assign ar_idx = s_axi_araddr[OCS_ADDR_W-1:OCS_IDX_LSB];

    always_comb begin
        status_val = 8'h00;
        status_val[OCS_ST_INT_EN] = internal_osc_en;
        status_val[OCS_ST_RC_EN] = rc_osc_en;
        status_val[OCS_ST_XTAL_EN] = crystal_osc_en;
        status_val[OCS_ST_STOP] = stop_active;
        status_val[OCS_ST_BUSY] = (sw_state_q != OCS_SW_RUN) || tb_park_q;
        status_val[OCS_ST_SRC_HI:OCS_ST_SRC_LO] = main_cur_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= OCS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= OCS_RESP_OKAY;
                if (ar_idx == OCS_IDX_OPTION) begin
                    s_axi_rdata <= {24'h000000, option_q};
                end else if (ar_idx == OCS_IDX_CONFIG) begin
                    s_axi_rdata <= {24'h000000, config_q};
                end else if (ar_idx == OCS_IDX_STATUS) begin
                    s_axi_rdata <= {24'h000000, status_val};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= OCS_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : ocs_top

// ===== testbench/ocs_osc_model.sv
// Behavioural oscillators and bus clock facing the clock select block
module ocs_osc_model #(
    parameter int HALF_INT = 200,
    parameter int HALF_RC = 300,
    parameter int HALF_XT = 500,
    parameter int HALF_BUS = 100
) (
    // Oscillator enables
    input wire logic internal_osc_en,
    input wire logic rc_osc_en,
    input wire logic crystal_osc_en,
    // Oscillator and pin levels
    output logic internal_osc_clock = 1'b0,
    output logic rc_osc_clock = 1'b0,
    output logic crystal_osc_clock = 1'b0,
    output logic crystal_amp_out,
    output logic bus_clock = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // A disabled oscillator stands still low
    always #(HALF_INT) internal_osc_clock = internal_osc_en ? ~internal_osc_clock : 1'b0;
    always #(HALF_RC) rc_osc_clock = rc_osc_en ? ~rc_osc_clock : 1'b0;
    always #(HALF_XT) crystal_osc_clock = crystal_osc_en ? ~crystal_osc_clock : 1'b0;
    always #(HALF_BUS) bus_clock = ~bus_clock;
    assign crystal_amp_out = crystal_osc_en ? ~crystal_osc_clock : 1'b1;
endmodule : ocs_osc_model

// ===== testbench/ocs_top_sva.sv
// Concurrent checks on the clock select block ports
module ocs_top_sva
    import ocs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Mode and clocks
    input wire logic osc_enable_from_sysint,
    input wire logic stop_mode,
    input wire logic main_ref_clock,
    input wire logic pll_ref_clock,
    input wire logic watchdog_ref_clock,
    // Oscillator enables
    input wire logic internal_osc_en,
    input wire logic rc_osc_en,
    input wire logic crystal_osc_en,
    // Bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_rc_xtal_excl: assert property (!(rc_osc_en && crystal_osc_en))
        else $error("rc and crystal enabled together");
    a_pll_copy: assert property (pll_ref_clock == main_ref_clock)
        else $error("pll reference differs from main reference");
    a_int_runs: assert property (
        (osc_enable_from_sysint && !stop_mode) [*4] |-> internal_osc_en)
        else $error("internal oscillator off outside stop");
    a_main_still: assert property (
        (!internal_osc_en && !rc_osc_en && !crystal_osc_en) [*6] |=> $stable(main_ref_clock))
        else $error("main reference moves with all oscillators off");
    a_wd_off: assert property (!internal_osc_en [*6] |-> !watchdog_ref_clock)
        else $error("watchdog clock high with internal oscillator off");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule : ocs_top_sva

bind ocs_top ocs_top_sva u_sva (
    .sys_clk, .rst_n, .osc_enable_from_sysint,
    .stop_mode, .main_ref_clock, .pll_ref_clock, .watchdog_ref_clock,
    .internal_osc_en, .rc_osc_en, .crystal_osc_en, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// ===== testbench/ocs_top_tb.sv
// Self-checking bench for the oscillator clock select block
module ocs_top_tb
    import ocs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WIN = 480;
    localparam int P_INT = 8;
    localparam int P_RC = 12;
    localparam int P_XT = 20;
    localparam int P_BUS = 4;
    localparam logic [OCS_ADDR_W-1:0] A_OPT = {OCS_IDX_OPTION, 2'b00};
    localparam logic [OCS_ADDR_W-1:0] A_CFG = {OCS_IDX_CONFIG, 2'b00};
    localparam logic [OCS_ADDR_W-1:0] A_ST = {OCS_IDX_STATUS, 2'b00};
    localparam logic [OCS_ADDR_W-1:0] A_BAD = 18'h00100;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] option_strap = 2'h0;
    logic osc_enable_from_sysint = 1'b1;
    logic stop_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic break_mode = 1'b0;
    logic internal_osc_clock, rc_osc_clock, crystal_osc_clock, crystal_amp_out, bus_clock;
    logic main_ref_clock, pll_ref_clock, timebase_ref_clock, watchdog_ref_clock, osc_out_pin;
    logic internal_osc_en, rc_osc_en, crystal_osc_en;
    logic [OCS_ADDR_W-1:0] s_axi_awaddr = '0;
    logic [OCS_ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] cnt [5];
    int n_fail = 0;
    int n_compared = 0;

    ocs_osc_model #(.HALF_INT(P_INT * 25), .HALF_RC(P_RC * 25), .HALF_XT(P_XT * 25),
        .HALF_BUS(P_BUS * 25)) u_osc (
        .internal_osc_en, .rc_osc_en, .crystal_osc_en, .internal_osc_clock, .rc_osc_clock,
        .crystal_osc_clock, .crystal_amp_out, .bus_clock
    );
    ocs_top dut (
        .sys_clk, .rst_n, .internal_osc_clock, .rc_osc_clock, .crystal_osc_clock,
        .crystal_amp_out, .bus_clock, .option_strap, .osc_enable_from_sysint, .stop_mode,
        .wait_mode, .break_mode, .main_ref_clock, .pll_ref_clock, .timebase_ref_clock,
        .watchdog_ref_clock, .osc_out_pin, .internal_osc_en, .rc_osc_en, .crystal_osc_en,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    always #25 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Edge counts may differ by one through synchroniser phase
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp && got !== exp + 1 && got + 1 !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: count %h expected %h", $time, got, exp);
        end
    endtask : chk_near

    function automatic int rate(input int per);
        return (per == 0) ? 0 : WIN / per;
    endfunction : rate

    function automatic int main_per(input int s);
        return (s == 1) ? P_INT : (s == 2) ? P_RC : (s == 3) ? P_XT : 0;
    endfunction : main_per

    task automatic do_reset(input logic [1:0] strap);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        option_strap <= strap;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : do_reset

    task automatic axi_wr(input logic [OCS_ADDR_W-1:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic aw_p;
        logic w_p;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        while (aw_p || w_p) begin
            @(posedge sys_clk);
            if (aw_p && s_axi_awready === 1'b1) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask : axi_wr

    task automatic axi_rd(input logic [OCS_ADDR_W-1:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : axi_rd

    // Counts rising edges of the five clock outputs over one window
    task automatic measure();
        logic [4:0] prev;
        logic [4:0] cur;
        repeat (10) @(posedge sys_clk);
        foreach (cnt[i]) cnt[i] = '0;
        prev = {osc_out_pin, watchdog_ref_clock, timebase_ref_clock, pll_ref_clock,
                main_ref_clock};
        repeat (WIN) begin
            @(posedge sys_clk);
            cur = {osc_out_pin, watchdog_ref_clock, timebase_ref_clock, pll_ref_clock,
                   main_ref_clock};
            for (int i = 0; i < 5; i++) if (cur[i] && !prev[i]) cnt[i]++;
            prev = cur;
        end
    endtask : measure

    task automatic chk_counts(input int m, input int t, input int w, input int o);
        chk_near(cnt[0], rate(m));
        chk_near(cnt[1], rate(m));
        chk_near(cnt[2], rate(t));
        chk_near(cnt[3], rate(w));
        if (o >= 0) chk_near(cnt[4], rate(o));
    endtask : chk_counts

    initial begin
        #2_000_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            axi_rd(A_OPT, s, OCS_RESP_OKAY);
            axi_wr(A_OPT, 32'hff, OCS_RESP_OKAY);
            axi_rd(A_OPT, s, OCS_RESP_OKAY);
            axi_rd(A_CFG, OCS_CFG_RESET, OCS_RESP_OKAY);
            axi_wr(A_CFG, 32'hff, OCS_RESP_OKAY);
            axi_rd(A_CFG, OCS_CFG_MASK, OCS_RESP_OKAY);
            axi_wr(A_BAD, 32'h1, OCS_RESP_SLVERR);
            axi_rd(A_BAD, 32'h0, OCS_RESP_SLVERR);
            for (int t = 0; t < 3; t++) begin
                axi_wr(A_CFG, t, OCS_RESP_OKAY);
                wait_mode <= (t == 1);
                break_mode <= (t == 1);
                measure();
                chk({crystal_osc_en, rc_osc_en, internal_osc_en}, {s == 3, s == 2, 1'b1});
                axi_rd(A_ST, (s << OCS_ST_SRC_LO) | {s == 3, s == 2, 1'b1}, OCS_RESP_OKAY);
                chk_counts(main_per(s),
                    (t == 0) ? P_INT : (t == 1) ? ((s == 2) ? P_RC : 0) : ((s == 3) ? P_XT : 0),
                    P_INT, (s == 3) ? P_XT : (s == 0) ? 0 : P_BUS);
            end
            for (int k = 0; k < 2; k++) begin
                axi_wr(A_CFG, k ? 32'h1c : 32'h0, OCS_RESP_OKAY);
                stop_mode <= 1'b1;
                measure();
                chk({crystal_osc_en, rc_osc_en, internal_osc_en},
                    k ? {s == 3, s == 2, 1'b0} : 3'h1);
                chk_counts(k ? ((s >= 2) ? main_per(s) : 0) : ((s == 1) ? P_INT : 0),
                    k ? 0 : P_INT, k ? 0 : P_INT, -1);
                stop_mode <= 1'b0;
            end
            osc_enable_from_sysint <= 1'b0;
            measure();
            chk({crystal_osc_en, rc_osc_en, internal_osc_en}, 3'h0);
            chk_counts(0, 0, 0, -1);
            osc_enable_from_sysint <= 1'b1;
            $display("tests done for main source code %0d", s);
        end
        give_verdict();
    end
endmodule : ocs_top_tb
